/* bench/cmd_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module cmd_host_model
  import flash_cmd_pkg::*;
(
  input wire logic clk,
  output logic [11:0] cpuAddr,
  output logic [7:0] cpuWdata,
  output logic cpuWrite,
  output logic cpuRead,
  output logic [11:0] dbgAddr,
  output logic [7:0] dbgWdata,
  output logic dbgWrite,
  output logic [7:0] dbgCommand
);
  initial begin
    {cpuAddr, dbgAddr} = {2{FLASH_COMMAND_ADDR}};
    {cpuWdata, dbgWdata, cpuWrite, cpuRead, dbgWrite} = '0;
    dbgCommand = DBG_WRITE_REG;
  end
  // Strobe stays up across back-to-back bytes
  task automatic put(input logic dbg, input logic [7:0] b);
    @(posedge clk);
    cpuAddr <= FLASH_COMMAND_ADDR;
    cpuWrite <= !dbg;
    dbgWrite <= dbg;
    cpuWdata <= b;
    dbgWdata <= b;
  endtask
  task automatic get(input logic [11:0] a);
    @(posedge clk);
    cpuAddr <= a;
    cpuRead <= 1'b1;
  endtask
  // Released data flips so stale bytes never look valid
  task automatic idle();
    @(posedge clk);
    {cpuWrite, dbgWrite, cpuRead} <= '0;
    cpuWdata <= ~cpuWdata;
    dbgWdata <= ~dbgWdata;
  endtask
endmodule
`default_nettype wire

/* bench/flash_command_unlock_protect_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
module flash_command_unlock_protect_assertions
  import flash_cmd_pkg::*;
#(
  parameter int PAGE_BITS = 3
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [11:0] cpuAddr,
  input wire logic [7:0] cpuWdata,
  input wire logic cpuWrite,
  input wire logic cpuRead,
  input wire logic [7:0] dbgWdata,
  input wire logic dbgWrite,
  input wire logic [PAGE_BITS-1:0] pageSelect,
  input wire logic read_protect_option,
  input wire logic write_protect_option,
  input wire logic [1:0] oscillator_mode_select,
  input wire logic watchdogRefresh,
  input wire logic stopRecovery,
  input wire logic [7:0] readData,
  input wire logic pageEraseStart,
  input wire logic [PAGE_BITS-1:0] erasePage,
  input wire logic massEraseStart,
  input wire logic sectorProtectOpen,
  input wire logic userCodeReadable,
  input wire logic watchdogRunning,
  input wire logic [1:0] oscDriveMode
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence cw(b);
    cpuWrite && !dbgWrite && cpuAddr == FLASH_COMMAND_ADDR && cpuWdata == b;
  endsequence
  // ----
  // Checks
  // ----
  chk_page_seq: assert property ((write_protect_option[*3] ##0
    cw(CMD_UNLOCK_FIRST)) ##1 cw(CMD_UNLOCK_SECOND) ##1
    (write_protect_option and cw(CMD_PAGE_ERASE)) |-> ##2 pageEraseStart)
    else $error("page erase missing");
  chk_page_value: assert property (pageEraseStart |->
    erasePage == $past(pageSelect)) else $error("wrong page");
  chk_mass_debug: assert property (massEraseStart |->
    $past(dbgWrite && dbgWdata == CMD_MASS_ERASE, 2))
    else $error("mass erase without debugger");
  chk_wrong_relock: assert property (cw(CMD_UNLOCK_FIRST) ##1
    (cpuWrite && !dbgWrite && cpuAddr == FLASH_COMMAND_ADDR &&
    cpuWdata != CMD_UNLOCK_SECOND) ##1 cw(CMD_UNLOCK_SECOND) ##1
    cw(CMD_PAGE_ERASE) |-> ##2 !pageEraseStart) else $error("no relock");
  chk_protect_open: assert property (cw(CMD_PROTECT_ACCESS) |->
    ##2 sectorProtectOpen) else $error("protect access not open");
  chk_other_read: assert property (cpuRead &&
    cpuAddr != FLASH_COMMAND_ADDR |=> readData == 8'h00)
    else $error("read data leak");
  chk_read_hide: assert property (!read_protect_option[*4] |->
    !userCodeReadable) else $error("code readable");
  chk_osc_mode: assert property ($stable(oscillator_mode_select)[*4]
    |-> oscDriveMode == oscillator_mode_select) else $error("osc mode");
  chk_wdog_stop: assert property (stopRecovery && !watchdogRefresh
    |=> !watchdogRunning) else $error("watchdog not stopped");
  cov_page: cover property (pageEraseStart);
  cov_mass: cover property (massEraseStart);
  cov_protect: cover property (cw(CMD_PROTECT_ACCESS));
endmodule
bind flash_command_unlock_protect flash_command_unlock_protect_assertions
  #(.PAGE_BITS(PAGE_BITS)) i_chk (.*);
`default_nettype wire

/* bench/flash_command_unlock_protect_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin \
  miscompares++; $display("unexpected %0t: got %h want %h", $time, a, e); \
  end end
module flash_command_unlock_protect_tb
  import flash_cmd_pkg::*;
;
  logic clk, rst, cpuWrite, cpuRead, dbgWrite;
  logic [11:0] cpuAddr, dbgAddr;
  logic [7:0] cpuWdata, dbgWdata, dbgCommand, readData, b;
  logic [2:0] pageSelect, erasePage;
  logic read_protect_option, write_protect_option, watchdogAlwaysOn;
  logic brownout_always_on, watchdogRefresh, stopRecovery, stopMode;
  logic brownoutOffRequest, pageEraseStart, massEraseStart;
  logic sectorProtectOpen, userCodeReadable, dbgWriteRejected;
  logic watchdogRunning, brownoutEnable;
  logic [1:0] oscillator_mode_select, oscDriveMode;
  logic [4:0] want;
  logic [4:0] expQ[$];
  logic [31:0] lfsr = 32'h5D9A;
  int miscompares, num_checks;
  flash_command_unlock_protect #(.PAGE_BITS(3)) i_dut (.*);
  cmd_host_model i_host (.*);
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic stop_test();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic settle();
    repeat (4) @(posedge clk);
  endtask
  task automatic seq3(input logic d, input logic [7:0] c);
    i_host.put(d, CMD_UNLOCK_FIRST);
    i_host.put(d, CMD_UNLOCK_SECOND);
    i_host.put(d, c);
    i_host.idle();
    repeat (3) @(posedge clk);
  endtask
  task automatic rd(input logic [11:0] a);
    i_host.get(a);
    i_host.idle();
    #1;
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Erase pulses are matched against the oldest noted expectation
  always @(negedge clk) begin
    if (!rst && (pageEraseStart || massEraseStart)) begin
      want = expQ.size() ? expQ.pop_front() : 'x;
      `CHK({massEraseStart, pageEraseStart, pageEraseStart ? erasePage : 3'h0}, want)
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    stop_test();
  end
  initial begin
    {rst, read_protect_option, write_protect_option} = 3'b111;
    {watchdogAlwaysOn, brownout_always_on, oscillator_mode_select} = 4'hF;
    {pageSelect, watchdogRefresh, stopRecovery} = '0;
    {stopMode, brownoutOffRequest} = '0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(FLASH_COMMAND_ADDR);
    `CHK(readData, 8'h18)
    rd(12'hFF0);
    `CHK(readData, 8'h00)
    repeat (3) begin
      lfsr = nxt(lfsr);
      pageSelect <= lfsr[2:0];
      expQ.push_back({2'b01, lfsr[2:0]});
      seq3(1'b0, CMD_PAGE_ERASE);
    end
    i_host.put(1'b0, CMD_PAGE_ERASE);
    i_host.idle();
    lfsr = nxt(lfsr);
    b = (lfsr[7:0] inside {8'h73, 8'h8C, 8'h5E}) ? 8'h00 : lfsr[7:0];
    i_host.put(1'b0, CMD_UNLOCK_FIRST);
    i_host.put(1'b0, b);
    i_host.put(1'b0, CMD_UNLOCK_SECOND);
    i_host.put(1'b0, CMD_PAGE_ERASE);
    i_host.idle();
    repeat (3) @(posedge clk);
    seq3(1'b0, CMD_MASS_ERASE);
    expQ.push_back(5'h10);
    seq3(1'b1, CMD_MASS_ERASE);
    write_protect_option <= 1'b0;
    settle();
    seq3(1'b0, CMD_PAGE_ERASE);
    expQ.push_back(5'h10);
    seq3(1'b1, CMD_MASS_ERASE);
    write_protect_option <= 1'b1;
    read_protect_option <= 1'b0;
    settle();
    `CHK(userCodeReadable, 1'b0)
    i_host.put(1'b1, CMD_PAGE_ERASE);
    i_host.idle();
    #1 `CHK(dbgWriteRejected, 1'b1)
    read_protect_option <= 1'b1;
    settle();
    `CHK(userCodeReadable, 1'b1)
    // Reset in mid-sequence must drop the unlock
    i_host.put(1'b0, CMD_UNLOCK_FIRST);
    i_host.put(1'b0, CMD_UNLOCK_SECOND);
    i_host.idle();
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    i_host.put(1'b0, CMD_PAGE_ERASE);
    i_host.idle();
    rd(FLASH_COMMAND_ADDR);
    `CHK(readData, 8'h18)
    i_host.put(1'b0, CMD_PROTECT_ACCESS);
    i_host.idle();
    repeat (2) @(posedge clk);
    #1 `CHK(sectorProtectOpen, 1'b1)
    for (int m = 0; m < 4; m++) begin
      oscillator_mode_select <= m[1:0];
      settle();
      #1 `CHK(oscDriveMode, m[1:0])
    end
    watchdogRefresh <= 1'b1;
    @(posedge clk);
    watchdogRefresh <= 1'b0;
    #1 `CHK(watchdogRunning, 1'b1)
    stopRecovery <= 1'b1;
    @(posedge clk);
    stopRecovery <= 1'b0;
    #1 `CHK(watchdogRunning, 1'b0)
    {stopMode, brownoutOffRequest} <= 2'b11;
    settle();
    `CHK(brownoutEnable, 1'b1)
    brownout_always_on <= 1'b0;
    settle();
    `CHK(brownoutEnable, 1'b0)
    `CHK(expQ.size() == 0, 1'b1)
    stop_test();
  end
endmodule
`default_nettype wire

/* design/flash_cmd_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface flash_cmd_if;
  logic cmdStrobe;
  logic [7:0] cmdByte;
  logic fromDebug;
  logic [1:0] lockCode;
  logic pageStart;
  logic massStart;
  logic protectOpen;
  modport decoder(input cmdStrobe, cmdByte, fromDebug,
    output lockCode, pageStart, massStart, protectOpen);
  modport owner(output cmdStrobe, cmdByte, fromDebug,
    input lockCode, pageStart, massStart, protectOpen);
endinterface
`default_nettype wire

/* design/flash_cmd_pkg.sv */
package flash_cmd_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [11:0] FLASH_COMMAND_ADDR = 12'hFF8;
  localparam logic [7:0] FLASH_COMMAND_RESET = 8'h00;
  // ----------------------------------------
  // Command codes
  // ----------------------------------------
  localparam logic [7:0] CMD_UNLOCK_FIRST = 8'h73;
  localparam logic [7:0] CMD_UNLOCK_SECOND = 8'h8C;
  localparam logic [7:0] CMD_PAGE_ERASE = 8'h95;
  localparam logic [7:0] CMD_MASS_ERASE = 8'h63;
  localparam logic [7:0] CMD_PROTECT_ACCESS = 8'h5E;
  localparam logic [7:0] DBG_WRITE_REG = 8'h08;
  // ----------------------------------------
  // Flash control register window
  // ----------------------------------------
  localparam logic [11:0] FLASH_CTRL_FIRST = 12'hFF8;
  localparam logic [11:0] FLASH_CTRL_LAST = 12'hFFF;
  // ----------------------------------------
  // Oscillator option codes (erased flash reads as OSC_MODE_MAX)
  // ----------------------------------------
  localparam logic [1:0] OSC_MODE_RC = 2'h0;
  localparam logic [1:0] OSC_MODE_MAX = 2'h3;
  // ----------------------------------------
  // Status field positions
  // ----------------------------------------
  localparam int STAT_UNLOCK_LO = 0;
  localparam int STAT_PROTECT_EN = 2;
  localparam int STAT_READ_PROT = 3;
  localparam int STAT_WRITE_PROT = 4;

  typedef enum logic [1:0] {
    LOCKED,
    FIRST_SEEN,
    UNLOCKED
  } lock_state_t;
endpackage

/* design/flash_command_unlock_protect.sv */
`timescale 1ns/10ps
`default_nettype none
module flash_command_unlock_protect
  import flash_cmd_pkg::*;
#(
  parameter int PAGE_BITS = 3
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [11:0] cpuAddr,
  input wire logic [7:0] cpuWdata,
  input wire logic cpuWrite,
  input wire logic cpuRead,
  input wire logic [11:0] dbgAddr,
  input wire logic [7:0] dbgWdata,
  input wire logic dbgWrite,
  input wire logic [7:0] dbgCommand,
  input wire logic [PAGE_BITS-1:0] pageSelect,
  input wire logic read_protect_option,
  input wire logic write_protect_option,
  input wire logic watchdogAlwaysOn,
  input wire logic [1:0] oscillator_mode_select,
  input wire logic brownout_always_on,
  input wire logic watchdogRefresh,
  input wire logic stopRecovery,
  input wire logic stopMode,
  input wire logic brownoutOffRequest,
  output logic [7:0] readData,
  output logic pageEraseStart,
  output logic [PAGE_BITS-1:0] erasePage,
  output logic massEraseStart,
  output logic sectorProtectOpen,
  output logic userCodeReadable,
  output logic dbgWriteRejected,
  output logic watchdogRunning,
  output logic [1:0] oscDriveMode,
  output logic brownoutEnable
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  // Option pins are static straps but still come from outside the clock
  typedef struct packed {
    logic [1:0] syncRp;
    logic [1:0] syncWp;
    logic [1:0] syncWd;
    logic [1:0] syncBo;
    logic [3:0] syncOsc;
    logic [7:0] rdata;
    logic page;
    logic [PAGE_BITS-1:0] pageNum;
    logic mass;
    logic prot;
    logic readable;
    logic rejected;
    logic wdRun;
    logic [1:0] osc;
    logic boEn;
  } top_t;
  top_t r;
  top_t next_r;

  flash_cmd_if cmd();

  function automatic logic isCtrlAddr(input logic [11:0] a);
    return (a >= FLASH_CTRL_FIRST) && (a <= FLASH_CTRL_LAST);
  endfunction

  logic readProt;
  logic dbgCmdOk;
  logic cpuCmdHit;
  logic dbgCmdHit;
  logic [7:0] statusByte;

  // Level 0 of the synchronised option bit means protection active
  assign readProt = ~r.syncRp[1];

  // ----------------------------------------
  // Command source selection
  // ----------------------------------------
  // Debugger under read protect: only mass erase into command reg
  assign dbgCmdOk = !readProt ||
    (dbgWdata == CMD_MASS_ERASE);
  assign dbgCmdHit = dbgWrite && (dbgCommand == DBG_WRITE_REG) &&
    (dbgAddr == FLASH_COMMAND_ADDR) && dbgCmdOk;
  assign cpuCmdHit = cpuWrite && (cpuAddr == FLASH_COMMAND_ADDR);

  // Debugger wins a same-cycle collision; CPU write is dropped
  assign cmd.cmdStrobe = dbgCmdHit || (cpuCmdHit && !dbgWrite);
  assign cmd.cmdByte = dbgCmdHit ? dbgWdata : cpuWdata;
  assign cmd.fromDebug = dbgCmdHit;

  flash_unlock_seq u_seq (
    .clk(clk),
    .rst(rst),
    .writeProtect(r.syncWp[1]),
    .cmd(cmd)
  );

  // ----------------------------------------
  // Status byte
  // ----------------------------------------
  always_comb begin
    statusByte = 8'h00;
    statusByte[STAT_UNLOCK_LO +: 2] = cmd.lockCode;
    statusByte[STAT_PROTECT_EN] = r.prot;
    statusByte[STAT_READ_PROT] = r.syncRp[1];
    statusByte[STAT_WRITE_PROT] = r.syncWp[1];
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_r = r;
    next_r.syncRp = {r.syncRp[0], read_protect_option};
    next_r.syncWp = {r.syncWp[0], write_protect_option};
    next_r.syncWd = {r.syncWd[0], watchdogAlwaysOn};
    next_r.syncBo = {r.syncBo[0], brownout_always_on};
    next_r.syncOsc = {r.syncOsc[1:0], oscillator_mode_select};
    // Command register reads back as status, never as itself
    if (cpuRead && (cpuAddr == FLASH_COMMAND_ADDR)) begin
      next_r.rdata = statusByte;
    end else begin
      next_r.rdata = 8'h00;
    end
    next_r.page = cmd.pageStart;
    if (cmd.pageStart) begin
      next_r.pageNum = pageSelect;
    end
    next_r.mass = cmd.massStart;
    if (cmd.protectOpen) begin
      next_r.prot = 1'b1;
    end
    next_r.readable = r.syncRp[1];
    // Protected debugger writes outside the flash control window, or non-mass-erase commands, are refused
    next_r.rejected = dbgWrite && readProt &&
      ((dbgCommand == DBG_WRITE_REG) ?
       (!isCtrlAddr(dbgAddr) || (dbgAddr == FLASH_COMMAND_ADDR &&
        !dbgCmdOk)) : 1'b1);
    // Start wins over a same-cycle stop recovery
    if (r.syncWd[1] && watchdogRefresh) begin
      next_r.wdRun = 1'b1;
    end else if (stopRecovery) begin
      next_r.wdRun = 1'b0;
    end
    next_r.osc = r.syncOsc[3:2];
    // Brownout off only in stop, not always-on, and power bit written
    next_r.boEn = r.syncBo[1] || !stopMode ||
      !brownoutOffRequest;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '0;
      r.syncRp <= 2'h3;
      r.syncWp <= 2'h3;
      r.syncWd <= 2'h3;
      r.syncBo <= 2'h3;
      r.syncOsc <= {OSC_MODE_MAX, OSC_MODE_MAX};
      r.osc <= OSC_MODE_MAX;
      r.readable <= 1'b1;
      r.boEn <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign readData = r.rdata;
  assign pageEraseStart = r.page;
  assign erasePage = r.pageNum;
  assign massEraseStart = r.mass;
  assign sectorProtectOpen = r.prot;
  assign userCodeReadable = r.readable;
  assign dbgWriteRejected = r.rejected;
  assign watchdogRunning = r.wdRun;
  assign oscDriveMode = r.osc;
  assign brownoutEnable = r.boEn;
endmodule
`default_nettype wire

/* design/flash_unlock_seq.sv */
`timescale 1ns/10ps
`default_nettype none
module flash_unlock_seq
  import flash_cmd_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic writeProtect,
  flash_cmd_if.decoder cmd
);
  typedef struct packed {
    lock_state_t lock;
    logic page;
    logic mass;
    logic prot;
  } seq_t;
  seq_t cur;
  seq_t next_cur;

  always_comb begin
    next_cur = cur;
    next_cur.page = 1'b0;
    next_cur.mass = 1'b0;
    next_cur.prot = 1'b0;
    if (cmd.cmdStrobe) begin
      if (cmd.cmdByte == CMD_PROTECT_ACCESS) begin
        next_cur.prot = 1'b1;
        next_cur.lock = LOCKED;
      end else begin
        unique case (cur.lock)
          LOCKED: begin
            // Wrong opener stays locked
            next_cur.lock = (cmd.cmdByte == CMD_UNLOCK_FIRST) ?
              FIRST_SEEN : LOCKED;
          end
          FIRST_SEEN: begin
            next_cur.lock = (cmd.cmdByte == CMD_UNLOCK_SECOND) ?
              UNLOCKED : LOCKED;
          end
          UNLOCKED: begin
            // Every third byte ends the sequence, accepted or not
            next_cur.lock = LOCKED;
            if (cmd.cmdByte == CMD_PAGE_ERASE) begin
              next_cur.page = writeProtect;
            end else if (cmd.cmdByte == CMD_MASS_ERASE) begin
              // Debugger may mass erase even when write protected
              next_cur.mass = cmd.fromDebug;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cur <= '{lock: LOCKED, page: 1'b0, mass: 1'b0, prot: 1'b0};
    end else begin
      cur <= next_cur;
    end
  end

  assign cmd.lockCode = cur.lock;
  assign cmd.pageStart = cur.page;
  assign cmd.massStart = cur.mass;
  assign cmd.protectOpen = cur.prot;
endmodule
`default_nettype wire
